// file: uel_map.vh
// register map, field positions and timing constants of the usb line logic
`ifndef UEL_MAP_VH
`define UEL_MAP_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UEL_OFS_IRQ_STAT  12'hf62
`define UEL_OFS_ERR_STAT  12'hf63
`define UEL_OFS_IRQ_EN    12'hf36
`define UEL_OFS_ERR_EN    12'hf37
`define UEL_OFS_CTRL      12'hf6d
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UEL_BIT_PID       0
`define UEL_BIT_CRC5      1
`define UEL_BIT_CRC16     2
`define UEL_BIT_DFN8      3
`define UEL_BIT_BTO       4
`define UEL_BIT_STUFF     7
`define UEL_ERR_IMPL      8'h9f
`define UEL_BIT_SUMMARY   1
`define UEL_BIT_IDLE      4
`define UEL_IRQ_IMPL      8'h12
`define UEL_BIT_USB_EN    0
`define UEL_BIT_PULLUP    1
`define UEL_CTRL_IMPL     8'h03
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define UEL_RST_REG       8'h00
`define UEL_RST_CRC16     16'hffff
`define UEL_RST_CRC5      5'h1f
// ------------------------------------------------------------
// crc and timing constants
// ------------------------------------------------------------
`define UEL_POLY16        16'ha001
`define UEL_POLY5         5'h14
`define UEL_RES16         16'hb001
`define UEL_RES5          5'h06
`define UEL_STUFF_RUN     3'h6
`define UEL_CLK_MHZ       10
`define UEL_IDLE_US       3000
`define UEL_IDLE_CYC      16'h7530
`endif

// file: uel_core.v
// usb error enable, error flags, idle detect and serial line coding
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "uel_map.vh"
module uel_core #(
  parameter [15:0] IDLE_CYCLES = `UEL_IDLE_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [11:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire        irq,
  input  wire        tx_en,
  input  wire        tx_sop,
  input  wire        tx_valid,
  input  wire        tx_bit,
  output wire        tx_ready,
  output reg         tx_line_q,
  output wire        tx_line_oe,
  output wire [15:0] tx_crc16,
  input  wire        rx_sop,
  input  wire        rx_tick,
  input  wire        rx_line,
  input  wire        rx_eop,
  input  wire        rx_is_token,
  output reg         rx_bit_valid_q,
  output reg         rx_bit_q,
  input  wire        err_pid,
  input  wire        err_dfn8,
  input  wire        err_bto,
  output wire        usb_enable,
  output wire        pullup_en,
  output wire        usb_error_summary_flag
);

  // ----------------------------------------------------------
  // constants
  // ----------------------------------------------------------
  // mask of the error flag bits that have storage behind them
  localparam [7:0] ERR_IMPL = `UEL_ERR_IMPL;

  // ----------------------------------------------------------
  // register state
  // ----------------------------------------------------------
  // software visible registers
  reg  [7:0]  err_en_q;
  reg  [7:0]  err_stat_q;
  reg  [7:0]  irq_en_q;
  reg         idle_flag_q;
  reg  [7:0]  ctrl_q;

  // idle detect counter and its once-per-spell latch
  reg  [15:0] idle_cnt_q;
  reg         idle_done_q;

  // transmit run length and crc
  reg  [2:0]  tx_ones_q;
  reg  [15:0] tx_crc_q;

  // receive decoder history, run length and crc
  reg         rx_prev_q;
  reg  [2:0]  rx_ones_q;
  reg  [15:0] rx_crc16_q;
  reg  [4:0]  rx_crc5_q;

  // flag events, interrupt view and read mux
  wire [7:0]  err_evt;
  wire [7:0]  err_gated;
  wire [7:0]  irq_stat;
  reg  [7:0]  rd_mux;

  // register write decodes
  wire        wr_err_stat;
  wire        wr_err_en;
  wire        wr_irq_en;
  wire        wr_irq_stat;
  wire        wr_ctrl;

  // transmit stuffing request
  wire        stuff_now;

  // receive decode and error detection
  wire        rx_raw;
  wire        rx_stuffed;
  wire        rx_keep;
  wire        stuff_err;
  wire        crc16_err;
  wire        crc5_err;

  // idle detect set pulse
  wire        idle_set;

  // ----------------------------------------------------------
  // register write decodes
  // ----------------------------------------------------------
  // every decode carries ce so a frozen block ignores the bus
  assign wr_err_stat = ce & reg_wr & (reg_addr == `UEL_OFS_ERR_STAT);
  assign wr_err_en   = ce & reg_wr & (reg_addr == `UEL_OFS_ERR_EN);
  assign wr_irq_en   = ce & reg_wr & (reg_addr == `UEL_OFS_IRQ_EN);
  assign wr_irq_stat = ce & reg_wr & (reg_addr == `UEL_OFS_IRQ_STAT);
  assign wr_ctrl     = ce & reg_wr & (reg_addr == `UEL_OFS_CTRL);

  // ----------------------------------------------------------
  // error events and sticky flags
  // ----------------------------------------------------------
  assign err_evt[`UEL_BIT_PID]   = err_pid;
  assign err_evt[`UEL_BIT_CRC5]  = crc5_err;
  assign err_evt[`UEL_BIT_CRC16] = crc16_err;
  assign err_evt[`UEL_BIT_DFN8]  = err_dfn8;
  assign err_evt[`UEL_BIT_BTO]   = err_bto;
  assign err_evt[6:5]            = 2'h0;
  assign err_evt[`UEL_BIT_STUFF] = stuff_err;

  // one sticky flag per implemented bit, set beats clear
  // an event in the same cycle as a clearing write survives
  // bits without storage are held at zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      always @(posedge clk) begin
        if (rst) begin
          err_stat_q[gi] <= 1'b0;
        end else if (ce) begin
          if (!ERR_IMPL[gi]) begin
            err_stat_q[gi] <= 1'b0;
          end else if (err_evt[gi]) begin
            err_stat_q[gi] <= 1'b1;
          end else if (wr_err_stat && !reg_wdata[gi]) begin
            err_stat_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // summary: or of enabled flags, recomputed every cycle
  // no storage, so an enable written over a set flag shows
  // on the very next clock and software cannot touch it
  assign err_gated              = err_stat_q & err_en_q;
  assign usb_error_summary_flag = |err_gated;

  // idle on bit 4, summary on bit 1, the rest read zero
  assign irq_stat = {3'h0, idle_flag_q, 2'h0, usb_error_summary_flag, 1'b0};
  assign irq      = |(irq_stat & irq_en_q);

  // ----------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------
  // written registers sit behind the ce gated decodes
  // enables and control: plain read/write, missing bits masked off
  // the error enable keeps only bits 7 and 4..0
  always @(posedge clk) begin
    if (rst) begin
      err_en_q    <= `UEL_RST_REG;
      irq_en_q    <= `UEL_RST_REG;
      ctrl_q      <= `UEL_RST_REG;
      idle_flag_q <= 1'b0;
    end else if (ce) begin
      if (wr_err_en) begin
        err_en_q <= reg_wdata & ERR_IMPL;
      end
      if (wr_irq_en) begin
        irq_en_q <= reg_wdata & `UEL_IRQ_IMPL;
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata & `UEL_CTRL_IMPL;
      end
      // idle flag: set wins, writing zero clears
      // writing one leaves it alone, like the error flags
      if (idle_set) begin
        idle_flag_q <= 1'b1;
      end else if (wr_irq_stat && !reg_wdata[`UEL_BIT_IDLE]) begin
        idle_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // module enable and pull-up
  // ----------------------------------------------------------
  // pull-up follows its control bit only, suspend does not drop it
  // firmware owns the attach decision, nothing here waits on vbus
  assign usb_enable = ctrl_q[`UEL_BIT_USB_EN];
  assign pullup_en  = ctrl_q[`UEL_BIT_PULLUP];

  // ----------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------
  // read mux, unmapped addresses and missing bits give zero
  // the master never waits, so the mux stays purely combinational
  always @* begin
    rd_mux = 8'h00;
    case (reg_addr)
      `UEL_OFS_ERR_EN:   rd_mux = err_en_q;
      `UEL_OFS_ERR_STAT: rd_mux = err_stat_q;
      `UEL_OFS_IRQ_EN:   rd_mux = irq_en_q;
      `UEL_OFS_IRQ_STAT: rd_mux = irq_stat;
      `UEL_OFS_CTRL:     rd_mux = ctrl_q;
      default:           rd_mux = 8'h00;
    endcase
  end

  // data register, zero outside the cycle after a read strobe
  // so a stale value never looks like a fresh answer
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------
  // idle detect
  // ----------------------------------------------------------
  // counts cycles with no received bit; flags once per quiet spell
  // the count parks at its end and idle_done_q keeps the flag from repeating
  // until traffic restarts it
  // a tick in the set cycle wins over the set
  assign idle_set = ~idle_done_q & (idle_cnt_q == IDLE_CYCLES) & ~rx_tick;

  always @(posedge clk) begin
    if (rst) begin
      idle_cnt_q  <= 16'h0000;
      idle_done_q <= 1'b0;
    end else if (ce) begin
      // traffic or a disabled module restarts the count
      if (rx_tick || !usb_enable) begin
        idle_cnt_q  <= 16'h0000;
        idle_done_q <= 1'b0;
      end else if (idle_set) begin
        idle_done_q <= 1'b1;
      end else if (idle_cnt_q != IDLE_CYCLES) begin
        idle_cnt_q <= idle_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------
  // transmit: stuffing, nrzi, crc16
  // ----------------------------------------------------------
  // after six ones a zero is forced in, holding off the source
  // the run count survives gaps in tx_valid; tx_sop, a zero bit or a stuff bit clears it
  // crc is kept inverted-out, ready to send lsb first
  assign stuff_now  = (tx_ones_q == `UEL_STUFF_RUN);
  assign tx_ready   = tx_en & ~stuff_now;
  assign tx_line_oe = tx_en;
  assign tx_crc16   = ~tx_crc_q;

  always @(posedge clk) begin
    if (rst) begin
      tx_line_q <= 1'b1;
      tx_ones_q <= 3'h0;
      tx_crc_q  <= `UEL_RST_CRC16;
    end else if (ce) begin
      // start of packet clears the run and seeds the crc
      if (tx_sop) begin
        tx_ones_q <= 3'h0;
        tx_crc_q  <= `UEL_RST_CRC16;
      end else if (tx_en && stuff_now) begin
        // stuffed zero, source held off this cycle
        tx_line_q <= ~tx_line_q;
        tx_ones_q <= 3'h0;
      end else if (tx_en && tx_valid) begin
        // data bit taken, crc runs on data bits only
        tx_crc_q <= (tx_crc_q >> 1) ^
                    ((tx_crc_q[0] ^ tx_bit) ? `UEL_POLY16 : 16'h0000);
        if (!tx_bit) begin
          tx_line_q <= ~tx_line_q;
          tx_ones_q <= 3'h0;
        end else begin
          tx_ones_q <= tx_ones_q + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // receive: nrzi decode, unstuff, crc check
  // ----------------------------------------------------------
  // a bit time with no change decodes as one
  // the bit after six ones must be a change, else a stuff error
  // crc residues are checked at end of packet only
  assign rx_raw     = (rx_line == rx_prev_q);
  assign rx_stuffed = (rx_ones_q == `UEL_STUFF_RUN);
  assign rx_keep    = rx_tick & ~rx_stuffed;
  assign stuff_err  = ce & rx_tick & rx_stuffed & rx_raw;
  assign crc16_err  = ce & rx_eop & ~rx_is_token &
                      (rx_crc16_q != `UEL_RES16);
  assign crc5_err   = ce & rx_eop & rx_is_token &
                      (rx_crc5_q != `UEL_RES5);

  always @(posedge clk) begin
    if (rst) begin
      rx_prev_q      <= 1'b1;
      rx_ones_q      <= 3'h0;
      rx_crc16_q     <= `UEL_RST_CRC16;
      rx_crc5_q      <= `UEL_RST_CRC5;
      rx_bit_valid_q <= 1'b0;
      rx_bit_q       <= 1'b0;
    end else if (ce) begin
      rx_bit_valid_q <= rx_keep & ~rx_sop;
      if (rx_sop) begin
        // line level before the first bit is the reference
        rx_prev_q  <= rx_line;
        rx_ones_q  <= 3'h0;
        rx_crc16_q <= `UEL_RST_CRC16;
        rx_crc5_q  <= `UEL_RST_CRC5;
      end else if (rx_tick) begin
        // one bit time: decode, then drop or keep
        rx_prev_q <= rx_line;
        if (rx_stuffed) begin
          rx_ones_q <= 3'h0; // stuffed bit dropped
        end else begin
          rx_bit_q   <= rx_raw;
          rx_ones_q  <= rx_raw ? rx_ones_q + 3'h1 : 3'h0;
          rx_crc16_q <= (rx_crc16_q >> 1) ^
                        ((rx_crc16_q[0] ^ rx_raw) ? `UEL_POLY16 : 16'h0000);
          rx_crc5_q  <= (rx_crc5_q >> 1) ^
                        ((rx_crc5_q[0] ^ rx_raw) ? `UEL_POLY5 : 5'h00);
        end
      end
    end
  end

endmodule

// file: uel_core_chk.sv
// assertion checker watching the ports of the usb line logic
`timescale 1ns/1ns
`include "uel_map.vh"
module uel_core_chk #(
  parameter [15:0] IDLE_CYCLES = 16'd20
) (
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire [11:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        irq,
  input wire        tx_sop,
  input wire        tx_valid,
  input wire        tx_bit,
  input wire        tx_ready,
  input wire        tx_line_q,
  input wire        err_pid,
  input wire        usb_enable,
  input wire        pullup_en,
  input wire        usb_error_summary_flag
);
  // --------------------------------------------------------
  // helper logic
  // --------------------------------------------------------
  reg  [7:0] en_q;
  wire       wr_ct = reg_wr && reg_addr == `UEL_OFS_CTRL;
  wire       acc   = tx_valid && tx_ready && !tx_sop;
  // shadow of the error enables, implemented bits only
  always @(posedge clk) begin
    if (rst)
      en_q <= 8'h00;
    else if (ce && reg_wr && reg_addr == `UEL_OFS_ERR_EN)
      en_q <= reg_wdata & `UEL_ERR_IMPL;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // --------------------------------------------------------
  // properties
  // --------------------------------------------------------
  property p_pid;
    err_pid && en_q[0] && !reg_wr |=> usb_error_summary_flag;
  endproperty
  a_pid: assert property (p_pid) else $error("enabled error not seen");
  property p_noen;
    en_q == 8'h00 |-> !usb_error_summary_flag;
  endproperty
  a_noen: assert property (p_noen) else $error("summary without enable");
  property p_rden;
    reg_rd && reg_addr == `UEL_OFS_ERR_EN |=> reg_rdata == en_q;
  endproperty
  a_rden: assert property (p_rden) else $error("enable readback wrong");
  property p_rd0;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
  property p_zero;
    acc && !tx_bit |=> tx_line_q != $past(tx_line_q);
  endproperty
  a_zero: assert property (p_zero) else $error("zero did not toggle");
  property p_one;
    acc && tx_bit |=> $stable(tx_line_q);
  endproperty
  a_one: assert property (p_one) else $error("one moved the line");
  property p_stuff;
    (acc && tx_bit) [*6] |=> !tx_ready ##1 tx_line_q != $past(tx_line_q);
  endproperty
  a_stuff: assert property (p_stuff) else $error("no stuff bit");
  property p_ctrl;
    wr_ct |=> pullup_en == $past(reg_wdata[1])
      && usb_enable == $past(reg_wdata[0]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl write lost");
  property p_pull;
    !wr_ct |=> $stable(pullup_en);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up moved");
  c_sum: cover property ($rose(usb_error_summary_flag));
  c_stuff: cover property (acc ##1 !tx_ready);
  c_irq: cover property ($rose(irq));
endmodule
bind uel_core uel_core_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
  .clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .irq, .tx_sop, .tx_valid, .tx_bit, .tx_ready, .tx_line_q, .err_pid,
  .usb_enable, .pullup_en, .usb_error_summary_flag);

// file: uel_host.sv
// behavioural usb host driving the receive side of the line logic
`timescale 1ns/1ns
module uel_host (
  input  wire clk,
  output reg  rx_sop,
  output reg  rx_tick,
  output reg  rx_line,
  output reg  rx_eop,
  output reg  rx_is_token
);
  // idle j, held there by the pull-up
  initial begin
    {rx_sop, rx_tick, rx_eop, rx_is_token} = 4'h0;
    rx_line = 1'b1;
  end
  // sends n raw bits nrzi coded, with no stuff bits put in
  task send(input [15:0] bits, input integer n);
    integer i;
    begin
      @(posedge clk) rx_sop <= 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk) rx_sop <= 1'b0;
        rx_tick <= 1'b1;
        if (!bits[i])
          rx_line <= ~rx_line; // zero toggles the line
      end
      @(posedge clk) rx_tick <= 1'b0;
      rx_eop <= 1'b1;
      rx_is_token <= 1'b1;
      @(posedge clk) rx_eop <= 1'b0;
      rx_line <= 1'b1; // released, back to idle j
    end
  endtask
endmodule

// file: usb_error_enable_line_coding_test.sv
// self-checking bench for the usb error enable and line coding logic
`timescale 1ns/1ns
`include "uel_map.vh"
`define CHK(got, exp) begin \
  check_count = check_count + 1; \
  if ((got) !== (exp)) begin \
    err_count = err_count + 1; \
    $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
  end \
end
module usb_error_enable_line_coding_test;
  reg         clk, rst, reg_wr, reg_rd, tx_en, tx_sop, tx_valid, tx_bit;
  reg         err_pid, err_dfn8, err_bto;
  reg  [11:0] reg_addr;
  reg  [7:0]  reg_wdata, d;
  wire [7:0]  reg_rdata;
  wire        irq, tx_ready, tx_line_q, usb_enable, pullup_en, sum;
  wire        rx_sop, rx_tick, rx_line, rx_eop, rx_is_token;
  integer     err_count = 0, check_count = 0, cyc = 0, i;
  uel_core #(.IDLE_CYCLES(16'd20)) uut (
    .clk(clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .tx_en(tx_en), .tx_sop(tx_sop),
    .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_ready(tx_ready),
    .tx_line_q(tx_line_q), .tx_line_oe(), .tx_crc16(), .rx_sop(rx_sop),
    .rx_tick(rx_tick), .rx_line(rx_line), .rx_eop(rx_eop),
    .rx_is_token(rx_is_token), .rx_bit_valid_q(), .rx_bit_q(),
    .err_pid(err_pid), .err_dfn8(err_dfn8), .err_bto(err_bto),
    .usb_enable(usb_enable), .pullup_en(pullup_en),
    .usb_error_summary_flag(sum));
  uel_host host (.clk(clk), .rx_sop(rx_sop), .rx_tick(rx_tick),
    .rx_line(rx_line), .rx_eop(rx_eop), .rx_is_token(rx_is_token));
  // --------------------------------------------------------
  // bus and stream tasks
  // --------------------------------------------------------
  task wr(input [11:0] a, input [7:0] v);
    begin
      @(posedge clk) reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk) reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [11:0] a);
    begin
      @(posedge clk) reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // called at a rising edge; checks the line left by the last bit
  task txbit(input b, input exp);
    integer n;
    begin
      n = 0;
      tx_valid <= 1'b1;
      tx_bit <= b;
      @(negedge clk);
      `CHK(tx_line_q, exp)
      while (!tx_ready && n < 4) begin
        @(negedge clk);
        n = n + 1;
      end
      @(posedge clk);
    end
  endtask
  // --------------------------------------------------------
  // scenarios
  // --------------------------------------------------------
  task t_regs;
    begin
      wr(12'h000, 8'hff);
      rd(12'h000);
      `CHK(d, 8'h00)
      for (i = 0; i < 8; i = i + 1) begin
        wr(`UEL_OFS_ERR_EN, 8'h01 << i);
        rd(`UEL_OFS_ERR_EN);
        `CHK(d, (8'h01 << i) & 8'h9f)
      end
    end
  endtask
  task t_flags;
    begin
      wr(`UEL_OFS_ERR_EN, 8'h01);
      @(posedge clk) {err_pid, err_dfn8, err_bto} <= 3'h7;
      @(posedge clk) {err_pid, err_dfn8, err_bto} <= 3'h0;
      #1 `CHK(sum, 1'b1)
      rd(`UEL_OFS_ERR_STAT);
      `CHK(d, 8'h19)
      wr(`UEL_OFS_ERR_STAT, 8'hfe);
      `CHK(sum, 1'b0)
      wr(`UEL_OFS_ERR_EN, 8'h08);
      `CHK(sum, 1'b1)
      wr(`UEL_OFS_IRQ_STAT, 8'h00);
      `CHK(sum, 1'b1)
      rd(`UEL_OFS_ERR_STAT);
      `CHK(d, 8'h18)
      wr(`UEL_OFS_ERR_STAT, 8'h00);
    end
  endtask
  task t_idle;
    begin
      wr(`UEL_OFS_CTRL, 8'h03);
      wr(`UEL_OFS_IRQ_EN, 8'h10);
      repeat (15) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      repeat (10) @(posedge clk);
      #1 `CHK(irq, 1'b1)
      `CHK(pullup_en, 1'b1)
      wr(`UEL_OFS_IRQ_EN, 8'h00);
      `CHK(irq, 1'b0)
      rd(`UEL_OFS_IRQ_STAT);
      `CHK(d & 8'h10, 8'h10)
      wr(`UEL_OFS_IRQ_STAT, 8'h00);
      wr(`UEL_OFS_IRQ_EN, 8'h10);
      `CHK(irq, 1'b0)
    end
  endtask
  // a zero, then seven ones: stuff bit after the sixth
  task t_tx;
    begin
      @(posedge clk) tx_en <= 1'b1;
      tx_sop <= 1'b1;
      @(posedge clk) tx_sop <= 1'b0;
      txbit(1'b0, 1'b1);
      for (i = 0; i < 7; i = i + 1)
        txbit(1'b1, 1'b0);
      tx_valid <= 1'b0;
      tx_en <= 1'b0;
      @(negedge clk) `CHK(tx_line_q, 1'b1)
    end
  endtask
  // eight ones with no transition on the receive side
  task t_rx;
    begin
      host.send(16'hffff, 8);
      rd(`UEL_OFS_ERR_STAT);
      `CHK(d & 8'h80, 8'h80)
    end
  endtask
  task tally_and_finish;
    begin
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // --------------------------------------------------------
  // clock, watchdog and main sequence
  // --------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  initial begin
    {rst, reg_wr, reg_rd, tx_en, tx_sop, tx_valid, tx_bit} = 7'h40;
    {err_pid, err_dfn8, err_bto, reg_addr, reg_wdata} = 23'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_flags;
    t_idle;
    t_tx;
    t_rx;
    tally_and_finish;
  end
endmodule
